//--- hw/sdbk_pkg.sv
package sdbk_pkg;
	localparam int CLK_PERIOD_NS         = 50;
	localparam int PRECHARGE_PERIOD_NS   = 20;
	localparam int ACTIVATE_TO_ACCESS_NS = 20;
	localparam int WRITE_RECOVERY_NS     = 20;
	localparam int REFRESH_PERIOD_NS     = 66;
	localparam int MODE_LOAD_NS          = 100;
	localparam int SELF_REFRESH_EXIT_NS  = 100;

	// Least times round up; never less than one cycle
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int PRE_CYC = min_cycles(PRECHARGE_PERIOD_NS);
	localparam int RCD_CYC = min_cycles(ACTIVATE_TO_ACCESS_NS);
	localparam int WR_CYC  = min_cycles(WRITE_RECOVERY_NS);
	localparam int RC_CYC  = min_cycles(REFRESH_PERIOD_NS);
	localparam int MRD_CYC = min_cycles(MODE_LOAD_NS);
	localparam int XSR_CYC = min_cycles(SELF_REFRESH_EXIT_NS);

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ERROR  = 8'h08;

	localparam int CTRL_CL_LSB   = 0;
	localparam int CTRL_BL_LSB   = 4;
	localparam int CTRL_FULL_BIT = 6;
	localparam int STAT_BANK_W   = 4;
	localparam int STAT_GATE_BIT = 16;
	localparam int STAT_BURST_BIT = 17;
	localparam int STAT_GBUSY_BIT = 18;
	localparam int ERR_REF_BIT   = 0;
	localparam int ERR_BUSY_BIT  = 1;

	localparam logic [1:0] CTRL_CL_RESET   = 2'h3;
	localparam logic [1:0] CTRL_BL_RESET   = 2'h3;
	localparam logic       CTRL_FULL_RESET = 1'b0;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		C_NOP, C_ACT, C_READ, C_WRITE, C_PRE, C_BST, C_REF, C_LMR
	} sdbk_cmd_t;

	typedef enum logic [2:0] {
		B_IDLE, B_ACTIVATING, B_ACTIVE, B_READ, B_WRITE, B_READ_AP, B_WRITE_AP,
		B_PRECHARGING
	} sdbk_bank_t;

	typedef struct packed {
		logic       csN;
		logic       rasN;
		logic       casN;
		logic       weN;
		logic       cke;
		logic       dqm;
		logic       autoPre;
		logic [1:0] bank;
	} sdbk_pins_t;

	localparam sdbk_pins_t PINS_RESET = '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
		cke: 1'b0, dqm: 1'b1, autoPre: 1'b0, bank: 2'h0};

	typedef struct packed {
		sdbk_cmd_t  kind;
		logic       autoPre;
		logic [1:0] bank;
	} sdbk_req_t;
endpackage

//--- hw/sdbk_bank_ctrl.sv
`timescale 1ns/1ps
module sdbk_bank_ctrl #(
	parameter int BANKS = 4
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        csN,
	input  wire logic        rasN,
	input  wire logic        casN,
	input  wire logic        weN,
	input  wire logic        cke,
	input  wire logic        dqm,
	input  wire logic        autoPre,
	input  wire logic [1:0]  bank,
	output logic             dqDriveEn,
	output logic [1:0]       dqDriveBank,
	output logic             wrDataTake,
	output logic [1:0]       wrDataBank,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	localparam int PRE_BOUND = sdbk_pkg::PRE_CYC;
	localparam int RCD_BOUND = sdbk_pkg::RCD_CYC;
	localparam int WR_BOUND  = sdbk_pkg::WR_CYC;

	function automatic sdbk_pkg::sdbk_cmd_t decode_cmd(input sdbk_pkg::sdbk_pins_t p);
		logic [2:0] s;
		s = {p.rasN, p.casN, p.weN};
		if (p.csN)
			return sdbk_pkg::C_NOP;
		case (s)
			3'h3:    return sdbk_pkg::C_ACT;
			3'h5:    return sdbk_pkg::C_READ;
			3'h4:    return sdbk_pkg::C_WRITE;
			3'h2:    return sdbk_pkg::C_PRE;
			3'h6:    return sdbk_pkg::C_BST;
			3'h1:    return sdbk_pkg::C_REF;
			3'h0:    return sdbk_pkg::C_LMR;
			default: return sdbk_pkg::C_NOP;
		endcase
	endfunction

	logic                    rstMeta;
	logic                    rstSync;
	sdbk_pkg::sdbk_pins_t    pinMeta;
	sdbk_pkg::sdbk_pins_t    pins;
	sdbk_pkg::sdbk_req_t     req;
	logic                    ckePrev;
	logic [3:0]              xsrCnt;
	logic [3:0]              next_xsrCnt;
	logic [3:0]              globalBusy;
	logic [3:0]              next_globalBusy;
	logic                    cmdGate;
	logic                    allIdle;
	sdbk_pkg::sdbk_bank_t    bankState [BANKS];
	sdbk_pkg::sdbk_bank_t    next_bankState [BANKS];
	logic [3:0]              bankTimer [BANKS];
	logic [3:0]              next_bankTimer [BANKS];
	logic                    burstActive;
	logic                    next_burstActive;
	logic                    burstWrite;
	logic                    next_burstWrite;
	logic [1:0]              burstBank;
	logic [1:0]              next_burstBank;
	logic [10:0]             burstLeft;
	logic [10:0]             next_burstLeft;
	logic                    burstFull;
	logic                    next_burstFull;
	logic [1:0]              pipeV;
	logic [1:0]              next_pipeV;
	logic [3:0]              pipeBank;
	logic [3:0]              next_pipeBank;
	logic                    next_dqDriveEn;
	logic [1:0]              next_dqDriveBank;
	logic                    next_wrDataTake;
	logic [1:0]              next_wrDataBank;
	logic                    busyHit;
	logic [1:0]              ctrlCl;
	logic [1:0]              ctrlBl;
	logic                    ctrlFull;
	logic [1:0]              errFlags;
	logic [1:0]              next_errFlags;
	logic [1:0]              next_ctrlCl;
	logic [1:0]              next_ctrlBl;
	logic                    next_ctrlFull;
	logic                    awHave;
	logic                    wHave;
	logic [7:0]              awAddrQ;
	logic [31:0]             wDataQ;
	logic [3:0]              wStrbQ;
	logic                    next_awHave;
	logic                    next_wHave;
	logic [7:0]              next_awAddrQ;
	logic [31:0]             next_wDataQ;
	logic [3:0]              next_wStrbQ;
	logic                    next_awready;
	logic                    next_wready;
	logic                    next_bvalid;
	logic [1:0]              next_bresp;
	logic                    next_arready;
	logic                    next_rvalid;
	logic [31:0]             next_rdata;
	logic [1:0]              next_rresp;
	logic [31:0]             statusWord;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// Pins are sampled twice before decode; command timing shifts two edges late
	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			pinMeta <= sdbk_pkg::PINS_RESET;
			pins    <= sdbk_pkg::PINS_RESET;
		end else begin
			pinMeta <= '{csN, rasN, casN, weN, cke, dqm, autoPre, bank};
			pins    <= pinMeta;
		end
	end

	assign cmdGate     = ckePrev && pins.cke && (xsrCnt == 4'h0);
	assign req.kind    = cmdGate ? decode_cmd(pins) : sdbk_pkg::C_NOP;
	assign req.autoPre = pins.autoPre;
	assign req.bank    = pins.bank;

	always_comb begin
		next_xsrCnt     = (!pins.cke) ? 4'(sdbk_pkg::XSR_CYC)
			: xsrCnt - ((xsrCnt != 4'h0) ? 4'h1 : 4'h0);
		next_globalBusy = globalBusy - ((globalBusy != 4'h0) ? 4'h1 : 4'h0);
		if (req.kind == sdbk_pkg::C_REF)
			next_globalBusy = 4'(sdbk_pkg::RC_CYC);
		else if (req.kind == sdbk_pkg::C_LMR)
			next_globalBusy = 4'(sdbk_pkg::MRD_CYC);
	end

	always_comb begin
		allIdle = 1'b1;
		for (int b = 0; b < BANKS; b++)
			allIdle = allIdle && (bankState[b] == sdbk_pkg::B_IDLE);
	end

	// Single burst source: a new read or write always takes it over
	always_comb begin
		logic cut;
		logic [10:0] beats;
		cut = 1'b0;
		beats = 11'h1 << ctrlBl;
		next_burstWrite = burstWrite;
		next_burstBank  = burstBank;
		next_burstFull  = burstFull;
		next_burstLeft  = burstLeft;
		next_burstActive = burstActive;
		next_pipeV      = {pipeV[0], 1'b0};
		next_pipeBank   = {pipeBank[1:0], burstBank};
		next_wrDataTake = 1'b0;
		next_wrDataBank = burstBank;
		if (req.kind == sdbk_pkg::C_READ || req.kind == sdbk_pkg::C_WRITE) begin
			next_burstWrite  = (req.kind == sdbk_pkg::C_WRITE);
			next_burstBank   = req.bank;
			next_burstFull   = ctrlFull;
			next_burstLeft   = beats - 11'h1;
			next_burstActive = ctrlFull || (beats != 11'h1);
			if (req.kind == sdbk_pkg::C_READ) begin
				next_pipeV[0]      = 1'b1;
				next_pipeBank[1:0] = req.bank;
			end else begin
				next_pipeV      = 2'h0;
				next_wrDataTake = !pins.dqm;
				next_wrDataBank = req.bank;
			end
		end else begin
			cut = (req.kind == sdbk_pkg::C_BST)
				|| (req.kind == sdbk_pkg::C_PRE && (req.autoPre || req.bank == burstBank));
			if (cut) begin
				next_burstActive = 1'b0;
			end else if (burstActive) begin
				next_burstLeft   = burstFull ? burstLeft : burstLeft - 11'h1;
				next_burstActive = burstFull || (burstLeft != 11'h1);
				next_pipeV[0]    = !burstWrite;
				next_wrDataTake  = burstWrite && !pins.dqm;
			end
		end
		// Read latency 3 taps the later stage; any other setting acts as 2
		next_dqDriveEn   = (ctrlCl == 2'h3) ? pipeV[1] : pipeV[0];
		next_dqDriveBank = (ctrlCl == 2'h3) ? pipeBank[3:2] : pipeBank[1:0];
		if (req.kind == sdbk_pkg::C_WRITE)
			next_dqDriveEn = 1'b0;
	end

	always_comb begin
		logic tgt;
		logic own;
		tgt = 1'b0;
		own = 1'b0;
		busyHit = 1'b0;
		for (int b = 0; b < BANKS; b++) begin
			tgt = (req.bank == 2'(b));
			own = next_burstActive && (next_burstBank == 2'(b));
			next_bankState[b] = bankState[b];
			next_bankTimer[b] = bankTimer[b] - ((bankTimer[b] != 4'h0) ? 4'h1 : 4'h0);
			case (bankState[b])
				sdbk_pkg::B_IDLE: begin
					if (req.kind == sdbk_pkg::C_ACT && tgt) begin
						next_bankState[b] = sdbk_pkg::B_ACTIVATING;
						next_bankTimer[b] = 4'(sdbk_pkg::RCD_CYC);
					end
				end
				sdbk_pkg::B_ACTIVATING, sdbk_pkg::B_PRECHARGING: begin
					busyHit = busyHit || (tgt && req.kind != sdbk_pkg::C_NOP);
					if (bankTimer[b] <= 4'h1)
						next_bankState[b] = (bankState[b] == sdbk_pkg::B_ACTIVATING)
							? sdbk_pkg::B_ACTIVE : sdbk_pkg::B_IDLE;
				end
				sdbk_pkg::B_ACTIVE, sdbk_pkg::B_READ, sdbk_pkg::B_WRITE: begin
					if (tgt && req.kind == sdbk_pkg::C_READ) begin
						next_bankState[b] = req.autoPre ? sdbk_pkg::B_READ_AP : sdbk_pkg::B_READ;
					end else if (tgt && req.kind == sdbk_pkg::C_WRITE) begin
						next_bankState[b] = req.autoPre ? sdbk_pkg::B_WRITE_AP : sdbk_pkg::B_WRITE;
						next_bankTimer[b] = 4'(sdbk_pkg::WR_CYC);
					end else if (req.kind == sdbk_pkg::C_PRE && (tgt || req.autoPre)) begin
						next_bankState[b] = sdbk_pkg::B_PRECHARGING;
						next_bankTimer[b] = 4'(sdbk_pkg::PRE_CYC);
					end else if (bankState[b] != sdbk_pkg::B_ACTIVE && !own) begin
						next_bankState[b] = sdbk_pkg::B_ACTIVE;
					end
				end
				sdbk_pkg::B_READ_AP: begin
					busyHit = busyHit || (tgt && req.kind != sdbk_pkg::C_NOP);
					if (!own) begin
						next_bankState[b] = sdbk_pkg::B_PRECHARGING;
						next_bankTimer[b] = 4'(sdbk_pkg::PRE_CYC);
					end
				end
				sdbk_pkg::B_WRITE_AP: begin
					busyHit = busyHit || (tgt && req.kind != sdbk_pkg::C_NOP);
					if (own) begin
						next_bankTimer[b] = 4'(sdbk_pkg::WR_CYC);
					end else if (bankTimer[b] <= 4'h1) begin
						next_bankState[b] = sdbk_pkg::B_PRECHARGING;
						next_bankTimer[b] = 4'(sdbk_pkg::PRE_CYC);
					end
				end
				default: next_bankState[b] = sdbk_pkg::B_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			ckePrev     <= 1'b0;
			xsrCnt      <= 4'(sdbk_pkg::XSR_CYC);
			globalBusy  <= 4'h0;
			burstActive <= 1'b0;
			burstWrite  <= 1'b0;
			burstBank   <= 2'h0;
			burstLeft   <= 11'h000;
			burstFull   <= 1'b0;
			pipeV       <= 2'h0;
			pipeBank    <= 4'h0;
			dqDriveEn   <= 1'b0;
			dqDriveBank <= 2'h0;
			wrDataTake  <= 1'b0;
			wrDataBank  <= 2'h0;
			for (int b = 0; b < BANKS; b++) begin
				bankState[b] <= sdbk_pkg::B_IDLE;
				bankTimer[b] <= 4'h0;
			end
		end else begin
			ckePrev     <= pins.cke;
			xsrCnt      <= next_xsrCnt;
			globalBusy  <= next_globalBusy;
			burstActive <= next_burstActive;
			burstWrite  <= next_burstWrite;
			burstBank   <= next_burstBank;
			burstLeft   <= next_burstLeft;
			burstFull   <= next_burstFull;
			pipeV       <= next_pipeV;
			pipeBank    <= next_pipeBank;
			dqDriveEn   <= next_dqDriveEn;
			dqDriveBank <= next_dqDriveBank;
			wrDataTake  <= next_wrDataTake;
			wrDataBank  <= next_wrDataBank;
			bankState   <= next_bankState;
			bankTimer   <= next_bankTimer;
		end
	end

	always_comb begin
		statusWord = 32'h0000_0000;
		for (int b = 0; b < BANKS; b++)
			statusWord[b*sdbk_pkg::STAT_BANK_W +: 3] = bankState[b];
		statusWord[sdbk_pkg::STAT_GATE_BIT]  = cmdGate;
		statusWord[sdbk_pkg::STAT_BURST_BIT] = burstActive;
		statusWord[sdbk_pkg::STAT_GBUSY_BIT] = (globalBusy != 4'h0);
	end

	// Register slave; a fresh error in the clearing cycle survives the clear
	always_comb begin
		logic doWrite;
		doWrite = awHave && wHave && !bvalid;
		next_awHave = awHave || (awvalid && awready);
		next_wHave  = wHave || (wvalid && wready);
		next_awAddrQ = (awvalid && awready) ? awaddr : awAddrQ;
		next_wDataQ  = (wvalid && wready) ? wdata : wDataQ;
		next_wStrbQ  = (wvalid && wready) ? wstrb : wStrbQ;
		next_bvalid = bvalid && !bready;
		next_bresp  = bresp;
		next_ctrlCl = ctrlCl;
		next_ctrlBl = ctrlBl;
		next_ctrlFull = ctrlFull;
		next_errFlags = errFlags;
		if (doWrite) begin
			next_awHave = 1'b0;
			next_wHave  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = sdbk_pkg::AXI_OKAY;
			if (awAddrQ == sdbk_pkg::REG_CTRL) begin
				if (wStrbQ[0]) begin
					next_ctrlCl   = wDataQ[sdbk_pkg::CTRL_CL_LSB +: 2];
					next_ctrlBl   = wDataQ[sdbk_pkg::CTRL_BL_LSB +: 2];
					next_ctrlFull = wDataQ[sdbk_pkg::CTRL_FULL_BIT];
				end
			end else if (awAddrQ == sdbk_pkg::REG_ERROR) begin
				if (wStrbQ[0])
					next_errFlags = errFlags & ~wDataQ[1:0];
			end else if (awAddrQ != sdbk_pkg::REG_STATUS) begin
				next_bresp = sdbk_pkg::AXI_SLVERR;
			end
		end
		if (((req.kind == sdbk_pkg::C_REF) || (req.kind == sdbk_pkg::C_LMR)) && !allIdle)
			next_errFlags[sdbk_pkg::ERR_REF_BIT] = 1'b1;
		if (busyHit || (globalBusy != 4'h0 && req.kind != sdbk_pkg::C_NOP))
			next_errFlags[sdbk_pkg::ERR_BUSY_BIT] = 1'b1;
		next_awready = !next_awHave;
		next_wready  = !next_wHave;
		next_rvalid  = rvalid && !rready;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = sdbk_pkg::AXI_OKAY;
			if (araddr == sdbk_pkg::REG_CTRL)
				next_rdata = {25'h0, ctrlFull, ctrlBl, 2'h0, ctrlCl};
			else if (araddr == sdbk_pkg::REG_STATUS)
				next_rdata = statusWord;
			else if (araddr == sdbk_pkg::REG_ERROR)
				next_rdata = {30'h0, errFlags};
			else begin
				next_rdata = 32'h0000_0000;
				next_rresp = sdbk_pkg::AXI_SLVERR;
			end
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			awHave <= 1'b0;
			wHave <= 1'b0;
			awAddrQ <= 8'h00;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= sdbk_pkg::AXI_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= sdbk_pkg::AXI_OKAY;
			ctrlCl <= sdbk_pkg::CTRL_CL_RESET;
			ctrlBl <= sdbk_pkg::CTRL_BL_RESET;
			ctrlFull <= sdbk_pkg::CTRL_FULL_RESET;
			errFlags <= 2'h0;
		end else begin
			awHave <= next_awHave;
			wHave <= next_wHave;
			awAddrQ <= next_awAddrQ;
			wDataQ <= next_wDataQ;
			wStrbQ <= next_wStrbQ;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			ctrlCl <= next_ctrlCl;
			ctrlBl <= next_ctrlBl;
			ctrlFull <= next_ctrlFull;
			errFlags <= next_errFlags;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSync);

	a_gate_holds_idle: assert property ((!cmdGate && bankState[0] == sdbk_pkg::B_IDLE) |=>
		bankState[0] == sdbk_pkg::B_IDLE) else $error("command acted while gated");
	a_pre_to_idle: assert property ((bankState[0] == sdbk_pkg::B_PRECHARGING) |->
		##[1:PRE_BOUND] bankState[0] == sdbk_pkg::B_IDLE) else $error("precharge did not end");
	a_act_to_active: assert property ((bankState[1] == sdbk_pkg::B_ACTIVATING) |->
		##[1:RCD_BOUND] bankState[1] == sdbk_pkg::B_ACTIVE) else $error("activate did not end");
	a_read_ap_entry: assert property ((req.kind == sdbk_pkg::C_READ && req.bank == 2'h1
		&& req.autoPre && bankState[1] == sdbk_pkg::B_ACTIVE)
		|=> bankState[1] == sdbk_pkg::B_READ_AP) else $error("read with precharge not entered");
	a_conc_precharge: assert property ((bankState[0] == sdbk_pkg::B_READ_AP
		&& req.kind == sdbk_pkg::C_READ && req.bank != 2'h0)
		|=> bankState[0] == sdbk_pkg::B_PRECHARGING) else $error("concurrent precharge late");
	// A write inside the latency window rightly kills the beat, so it is left out
	a_read_latency: assert property ((req.kind == sdbk_pkg::C_READ && ctrlCl == 2'h3)
		##1 (req.kind != sdbk_pkg::C_WRITE)[*2]
		|-> ##1 (dqDriveEn && dqDriveBank == $past(req.bank, 3))) else $error("read latency wrong");
	a_write_cut_read: assert property ((req.kind == sdbk_pkg::C_WRITE) |=> !dqDriveEn)
		else $error("read data after write");
	a_read_cut_write: assert property ((req.kind == sdbk_pkg::C_READ && burstActive
		&& burstWrite) |=> !wrDataTake) else $error("write data taken at read");
	a_write_switch: assert property ((req.kind == sdbk_pkg::C_WRITE && !pins.dqm)
		|=> (wrDataTake && wrDataBank == $past(req.bank))) else $error("write bank not switched");
	a_wr_recovery: assert property ((bankState[2] == sdbk_pkg::B_WRITE_AP
		&& req.kind == sdbk_pkg::C_READ && req.bank != 2'h2)
		|-> ##[1:WR_BOUND] bankState[2] == sdbk_pkg::B_PRECHARGING) else $error("recovery wrong");
	a_bst_stops: assert property ((req.kind == sdbk_pkg::C_BST) |=> !burstActive)
		else $error("burst not terminated");

	c_read_over_read: cover property (bankState[0] == sdbk_pkg::B_READ
		&& req.kind == sdbk_pkg::C_READ && req.bank == 2'h1);
	c_write_ap_cut: cover property (bankState[2] == sdbk_pkg::B_WRITE_AP
		&& req.kind == sdbk_pkg::C_WRITE && req.bank != 2'h2);
	c_refresh: cover property (req.kind == sdbk_pkg::C_REF && allIdle);
endmodule

//--- bench/sdbk_ctrl_model.sv
`timescale 1ns/1ps
module sdbk_ctrl_model (
	input  wire logic                mclk,
	input  wire logic                go,
	input  wire sdbk_pkg::sdbk_req_t req,
	output sdbk_pkg::sdbk_pins_t     pins
);
	sdbk_pkg::sdbk_req_t reqD;
	logic                lastRd;
	function automatic logic [2:0] enc(input sdbk_pkg::sdbk_cmd_t k);
		case (k)
			sdbk_pkg::C_ACT:   return 3'h3;
			sdbk_pkg::C_READ:  return 3'h5;
			sdbk_pkg::C_WRITE: return 3'h4;
			sdbk_pkg::C_PRE:   return 3'h2;
			sdbk_pkg::C_BST:   return 3'h6;
			sdbk_pkg::C_REF:   return 3'h1;
			sdbk_pkg::C_LMR:   return 3'h0;
			default:           return 3'h7;
		endcase
	endfunction
	initial begin
		pins = sdbk_pkg::PINS_RESET;
		lastRd = 1'b0;
	end
	always @(posedge mclk) begin
		reqD <= go ? req : '{sdbk_pkg::C_NOP, 1'b0, 2'h0};
		if (go) lastRd <= (req.kind == sdbk_pkg::C_READ);
		// Mask ahead of a write so read data cannot collide with it
		pins.dqm <= go && lastRd && req.kind == sdbk_pkg::C_WRITE;
		pins.csN <= (reqD.kind == sdbk_pkg::C_NOP);
		{pins.rasN, pins.casN, pins.weN} <= enc(reqD.kind);
		pins.cke <= 1'b1;
		pins.autoPre <= reqD.autoPre;
		pins.bank <= reqD.bank;
	end
endmodule

//--- bench/tb_sdbk_bank_ctrl.sv
`timescale 1ns/1ps
module tb_sdbk_bank_ctrl;
	logic                 mclk, rst_b, go, dqDriveEn, wrDataTake, awvalid, awready, wvalid;
	logic                 wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]           dqDriveBank, wrDataBank, bresp, rresp, r, n, m;
	logic [7:0]           awaddr, araddr;
	logic [31:0]          wdata, rdata, d;
	logic [3:0]           wstrb;
	logic                 apM;
	sdbk_pkg::sdbk_req_t  req;
	sdbk_pkg::sdbk_pins_t pins;
	sdbk_pkg::sdbk_cmd_t  kn, km;
	int                   n_mismatch, samples_checked, rdBeats[4], wrBeats[4];
	sdbk_ctrl_model sdbk_ctrl_model_i (.mclk(mclk), .go(go), .req(req), .pins(pins));
	sdbk_bank_ctrl sdbk_bank_ctrl_i (.mclk(mclk), .rst_b(rst_b), .csN(pins.csN),
		.rasN(pins.rasN), .casN(pins.casN), .weN(pins.weN), .cke(pins.cke), .dqm(pins.dqm),
		.autoPre(pins.autoPre), .bank(pins.bank), .dqDriveEn(dqDriveEn),
		.dqDriveBank(dqDriveBank), .wrDataTake(wrDataTake), .wrDataBank(wrDataBank),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (dqDriveEn === 1'b1) rdBeats[dqDriveBank]++;
		if (wrDataTake === 1'b1) wrBeats[wrDataBank]++;
	end
	task automatic results();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic axiW(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int i;
		@(posedge mclk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (i = 0; i < 40 && bvalid !== 1'b1; i++) begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		rs = bresp;
		bready <= 1'b0;
		if (i == 40) begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic axiR(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int i;
		@(posedge mclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 40 && rvalid !== 1'b1; i++) begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (i == 40) begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic cmd(input sdbk_pkg::sdbk_cmd_t k, input logic [1:0] b, input logic ap);
		@(posedge mclk);
		go <= 1'b1;
		req <= '{k, ap, b};
	endtask
	task automatic stop();
		@(posedge mclk);
		go <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	// A write cuts a read before the first read beat reaches the pins
	function automatic int expN(input sdbk_pkg::sdbk_cmd_t a, input sdbk_pkg::sdbk_cmd_t b);
		return (a == sdbk_pkg::C_READ && b == sdbk_pkg::C_WRITE) ? 0 : 1;
	endfunction
	initial begin
		{rst_b, go, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		req = '{sdbk_pkg::C_NOP, 1'b0, 2'h0};
		void'($urandom(32'h033A42D3));
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (10) @(posedge mclk);
		axiR(sdbk_pkg::REG_CTRL, d, r);
		chk(d[6:0], {sdbk_pkg::CTRL_FULL_RESET, sdbk_pkg::CTRL_BL_RESET, 2'h0,
			sdbk_pkg::CTRL_CL_RESET});
		axiR(8'hFC, d, r);
		chk(r, sdbk_pkg::AXI_SLVERR);
		axiW(8'hFC, 32'h0, r);
		chk(r, sdbk_pkg::AXI_SLVERR);
		axiW(sdbk_pkg::REG_CTRL, 32'h30 | $urandom_range(2, 3), r);
		chk(r, sdbk_pkg::AXI_OKAY);
		for (int s = 0; s < 8; s++) begin
			kn = s[0] ? sdbk_pkg::C_WRITE : sdbk_pkg::C_READ;
			km = s[1] ? sdbk_pkg::C_WRITE : sdbk_pkg::C_READ;
			apM = 1'($urandom_range(0, 1));
			n = 2'($urandom_range(0, 3));
			m = 2'(n + 2'($urandom_range(1, 3)));
			// Latency follows the parity of s so both settings meet every pair of commands
			axiW(sdbk_pkg::REG_CTRL, 32'h32 | 32'(^s[2:0]), r);
			chk(r, sdbk_pkg::AXI_OKAY);
			axiR(sdbk_pkg::REG_CTRL, d, r);
			chk(d, 32'h32 | 32'(^s[2:0]));
			cmd(sdbk_pkg::C_PRE, 2'h0, 1'b1);
			stop();
			cmd(sdbk_pkg::C_ACT, n, 1'b0);
			cmd(sdbk_pkg::C_ACT, m, 1'b0);
			stop();
			rdBeats = '{0, 0, 0, 0};
			wrBeats = '{0, 0, 0, 0};
			cmd(kn, n, s[2]);
			cmd(km, m, apM);
			stop();
			repeat (24) @(posedge mclk);
			chk(rdBeats[n] + wrBeats[n], expN(kn, km));
			chk(rdBeats[m] + wrBeats[m], 8);
			axiR(sdbk_pkg::REG_STATUS, d, r);
			chk(d[4 * n +: 3], s[2] ? sdbk_pkg::B_IDLE : sdbk_pkg::B_ACTIVE);
			chk(d[4 * m +: 3], apM ? sdbk_pkg::B_IDLE : sdbk_pkg::B_ACTIVE);
			chk(d[sdbk_pkg::STAT_GATE_BIT], 1'b1);
		end
		// Full page burst of length one code; only the terminate ends it
		axiW(sdbk_pkg::REG_CTRL, 32'h42 | 32'($urandom_range(0, 1)), r);
		chk(r, sdbk_pkg::AXI_OKAY);
		cmd(sdbk_pkg::C_PRE, 2'h0, 1'b1);
		stop();
		cmd(sdbk_pkg::C_REF, 2'h0, 1'b0);
		stop();
		cmd(sdbk_pkg::C_ACT, 2'h1, 1'b0);
		stop();
		rdBeats = '{0, 0, 0, 0};
		cmd(sdbk_pkg::C_READ, 2'h1, 1'b0);
		stop();
		cmd(sdbk_pkg::C_BST, 2'h1, 1'b0);
		stop();
		repeat (24) @(posedge mclk);
		// Terminate comes eight cycles after the read, one beat per cycle
		chk(rdBeats[1], 8);
		cmd(sdbk_pkg::C_REF, 2'h0, 1'b0);
		stop();
		axiR(sdbk_pkg::REG_ERROR, d, r);
		chk(d, 32'h1 << sdbk_pkg::ERR_REF_BIT);
		axiW(sdbk_pkg::REG_ERROR, 32'h3, r);
		axiR(sdbk_pkg::REG_ERROR, d, r);
		chk(d, 32'h0);
		results();
	end
endmodule
